/* File: design/fault_limit_map.vh */
`ifndef FAULT_LIMIT_MAP_VH
`define FAULT_LIMIT_MAP_VH

// Register command codes
`define CMD_OUT_UC_THR      8'h4B
`define CMD_OT_FAULT_THR    8'h4F
`define CMD_OT_ACTION       8'h50
`define CMD_OT_WARN_THR     8'h51
`define CMD_UT_WARN_THR     8'h52
`define CMD_UT_FAULT_THR    8'h53
`define CMD_UT_ACTION       8'h54
`define CMD_VIN_OV_THR      8'h55
`define CMD_VIN_OV_ACTION   8'h56
`define CMD_VIN_OV_WARN     8'h57
`define CMD_STATUS_BYTE     8'h78
`define CMD_STATUS_WORD     8'h79

// Reset values
`define RST_OUT_UC_THR      16'hDC3F
`define RST_OT_FAULT_THR    16'hEBE8
`define RST_OT_WARN_THR     16'hEB70
`define RST_UT_WARN_THR     16'hDC40
`define RST_UT_FAULT_THR    16'hE530
`define RST_VIN_OV_THR      16'hD3A0
`define RST_VIN_OV_WARN     16'hD34D
`define RST_ACTION          8'h80

// Action byte fields
`define ACT_RSVD_HI         7
`define ACT_RSVD_LO         6
`define ACT_RSVD_VAL        2'h2
`define ACT_MODE_HI         5
`define ACT_MODE_LO         3
`define ACT_MODE_NORETRY    3'h0
`define ACT_MODE_RETRY      3'h7
`define ACT_DLY_HI          2
`define ACT_DLY_LO          0

// Status bit positions
`define STS_OTHER_BIT       0
`define STS_TEMP_BIT        2
`define STS_INPUT_BIT       13

// Timing
`define CLK_HZ              50000000
`define RETRY_STEP_MS       35
`define RETRY_STEP_CYC      ((`CLK_HZ / 1000) * `RETRY_STEP_MS)

`endif

/* File: design/linear11_cmp.v */
`timescale 1ns/1ps
`default_nettype none
// Signed linear-eleven comparison: a > b
module linear11_cmp (
    input  wire [15:0] a,
    input  wire [15:0] b,
    output wire        greater
);
    wire signed [4:0]  ea = a[15:11];
    wire signed [4:0]  eb = b[15:11];
    wire signed [10:0] ma = a[10:0];
    wire signed [10:0] mb = b[10:0];
    wire signed [5:0]  emin = (ea < eb) ? {ea[4], ea} : {eb[4], eb};
    wire        [5:0]  sa = {ea[4], ea} - emin;
    wire        [5:0]  sb = {eb[4], eb} - emin;
    wire signed [47:0] va = {{37{ma[10]}}, ma} <<< sa[4:0];
    wire signed [47:0] vb = {{37{mb[10]}}, mb} <<< sb[4:0];
    assign greater = va > vb;
endmodule
`default_nettype wire

/* File: design/retry_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "fault_limit_map.vh"
// Counts (code+1) retry steps, pulses done
module retry_timer #(
    parameter STEP_CYC = `RETRY_STEP_CYC
) (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       start,
    input  wire [2:0] code,
    output reg        done
);
    reg [31:0] cyc_r;
    reg [3:0]  steps_r;
    reg        run_r;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cyc_r   <= 32'h0;
            steps_r <= 4'h0;
            run_r   <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                run_r   <= 1'b1;
                cyc_r   <= 32'h0;
                steps_r <= {1'b0, code} + 4'h1;
            end else if (run_r) begin
                if (cyc_r == STEP_CYC - 1) begin
                    cyc_r <= 32'h0;
                    if (steps_r == 4'h1) begin
                        run_r <= 1'b0;
                        done  <= 1'b1;
                    end
                    steps_r <= steps_r - 4'h1;
                end else begin
                    cyc_r <= cyc_r + 32'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/fault_limit_response_bank.v */
`timescale 1ns/1ps
`default_nettype none
`include "fault_limit_map.vh"
module fault_limit_response_bank #(
    parameter STEP_CYC = `RETRY_STEP_CYC
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        wr_en,
    input  wire [7:0]  cmd,
    input  wire [15:0] wr_data,
    output reg  [15:0] rd_data,
    input  wire        clear_faults,
    input  wire [15:0] temp_meas,
    input  wire [15:0] vin_meas,
    input  wire        run_cmd,
    output wire [15:0] output_undercurrent_threshold,
    output wire        output_enable,
    output wire        alert_n
);
    ////////////////////////////////////////////////////////////////////
    // Settings
    localparam [7:0] RST_ACT = `RST_ACTION;
    reg [15:0] uc_thr_r;
    reg [15:0] otf_thr_r;
    reg [15:0] otw_thr_r;
    reg [15:0] utw_thr_r;
    reg [15:0] utf_thr_r;
    reg [15:0] ovf_thr_r;
    reg [15:0] ovw_thr_r;
    reg [5:0]  ot_act_r;
    reg [5:0]  ut_act_r;
    reg [5:0]  ov_act_r;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            uc_thr_r  <= `RST_OUT_UC_THR;
            otf_thr_r <= `RST_OT_FAULT_THR;
            otw_thr_r <= `RST_OT_WARN_THR;
            utw_thr_r <= `RST_UT_WARN_THR;
            utf_thr_r <= `RST_UT_FAULT_THR;
            ovf_thr_r <= `RST_VIN_OV_THR;
            ovw_thr_r <= `RST_VIN_OV_WARN;
            ot_act_r  <= RST_ACT[5:0];
            ut_act_r  <= RST_ACT[5:0];
            ov_act_r  <= RST_ACT[5:0];
        end else if (wr_en) begin
            case (cmd)
                `CMD_OUT_UC_THR:    uc_thr_r  <= wr_data;
                `CMD_OT_FAULT_THR:  otf_thr_r <= wr_data;
                `CMD_OT_WARN_THR:   otw_thr_r <= wr_data;
                `CMD_UT_WARN_THR:   utw_thr_r <= wr_data;
                `CMD_UT_FAULT_THR:  utf_thr_r <= wr_data;
                `CMD_VIN_OV_THR:    ovf_thr_r <= wr_data;
                `CMD_VIN_OV_WARN:   ovw_thr_r <= wr_data;
                `CMD_OT_ACTION:     ot_act_r  <= wr_data[5:0];
                `CMD_UT_ACTION:     ut_act_r  <= wr_data[5:0];
                `CMD_VIN_OV_ACTION: ov_act_r  <= wr_data[5:0];
                default: ;
            endcase
        end
    end
    assign output_undercurrent_threshold = uc_thr_r;

    ////////////////////////////////////////////////////////////////////
    // Comparisons in linear-eleven encoding
    wire t_gt_otf;
    wire t_gt_otw;
    wire utw_gt_t;
    wire utf_gt_t;
    wire v_gt_ovf;
    wire v_gt_ovw;
    linear11_cmp c0 (.a(temp_meas), .b(otf_thr_r), .greater(t_gt_otf));
    linear11_cmp c1 (.a(temp_meas), .b(otw_thr_r), .greater(t_gt_otw));
    linear11_cmp c2 (.a(utw_thr_r), .b(temp_meas), .greater(utw_gt_t));
    linear11_cmp c3 (.a(utf_thr_r), .b(temp_meas), .greater(utf_gt_t));
    linear11_cmp c4 (.a(vin_meas), .b(ovf_thr_r), .greater(v_gt_ovf));
    linear11_cmp c5 (.a(vin_meas), .b(ovw_thr_r), .greater(v_gt_ovw));
    wire t_below_otw = !t_gt_otw && (temp_meas != otw_thr_r);
    wire t_above_utw = !utw_gt_t && (temp_meas != utw_thr_r);

    ////////////////////////////////////////////////////////////////////
    // Fault and warning flags; set wins over clear
    reg ot_fault_r;
    reg ut_fault_r;
    reg ov_fault_r;
    reg overtemp_warning_flag;
    reg undertemp_warning_flag;
    reg input_overvoltage_warning_flag;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ot_fault_r <= 1'b0;
            ut_fault_r <= 1'b0;
            ov_fault_r <= 1'b0;
            overtemp_warning_flag <= 1'b0;
            undertemp_warning_flag <= 1'b0;
            input_overvoltage_warning_flag <= 1'b0;
        end else begin
            if (t_gt_otf)
                ot_fault_r <= 1'b1;
            else if (t_below_otw)
                ot_fault_r <= 1'b0;
            if (utf_gt_t)
                ut_fault_r <= 1'b1;
            else if (t_above_utw)
                ut_fault_r <= 1'b0;
            if (v_gt_ovf)
                ov_fault_r <= 1'b1;
            else if (clear_faults)
                ov_fault_r <= 1'b0;
            if (t_gt_otw)
                overtemp_warning_flag <= 1'b1;
            else if (clear_faults)
                overtemp_warning_flag <= 1'b0;
            if (utw_gt_t)
                undertemp_warning_flag <= 1'b1;
            else if (clear_faults)
                undertemp_warning_flag <= 1'b0;
            if (v_gt_ovw)
                input_overvoltage_warning_flag <= 1'b1;
            else if (clear_faults)
                input_overvoltage_warning_flag <= 1'b0;
        end
    end

    wire temperature_flag = ot_fault_r | ut_fault_r | overtemp_warning_flag
                            | undertemp_warning_flag;
    wire other_event_flag = input_overvoltage_warning_flag | ov_fault_r;
    wire input_flag = input_overvoltage_warning_flag | ov_fault_r;
    wire [15:0] status_word = ({15'h0, other_event_flag} << `STS_OTHER_BIT)
                            | ({15'h0, temperature_flag} << `STS_TEMP_BIT)
                            | ({15'h0, input_flag} << `STS_INPUT_BIT);
    assign alert_n = ~(|status_word);

    ////////////////////////////////////////////////////////////////////
    // Response engine
    localparam S_RUN  = 3'b001;
    localparam S_HOLD = 3'b010;
    localparam S_WAIT = 3'b100;

    reg  [2:0] state_r;
    reg  [5:0] act_r;
    reg        fault_d_r;
    wire       any_fault = ot_fault_r | ut_fault_r | ov_fault_r;
    wire [2:0] rise = {ot_fault_r, ut_fault_r, ov_fault_r} & ~{3{fault_d_r}};
    wire [5:0] new_act = rise[2] ? ot_act_r : (rise[1] ? ut_act_r : ov_act_r);
    wire       tmr_start = (state_r == S_RUN) && run_cmd && (|rise);
    wire       tmr_done;

    retry_timer #(.STEP_CYC(STEP_CYC)) timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (tmr_start),
        .code    (new_act[`ACT_DLY_HI:`ACT_DLY_LO]),
        .done    (tmr_done)
    );

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r   <= S_RUN;
            act_r     <= 6'h0;
            fault_d_r <= 1'b0;
        end else begin
            fault_d_r <= any_fault;
            case (state_r)
                S_RUN: begin
                    if (|rise) begin
                        act_r <= new_act;
                        if (new_act[`ACT_MODE_HI:`ACT_MODE_LO] == `ACT_MODE_RETRY)
                            state_r <= S_WAIT;
                        else
                            state_r <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (!any_fault && clear_faults)
                        state_r <= S_RUN;
                end
                S_WAIT: begin
                    if (!run_cmd)
                        state_r <= S_HOLD;
                    else if (tmr_done)
                        state_r <= S_RUN;
                end
                default: state_r <= S_RUN;
            endcase
        end
    end
    assign output_enable = run_cmd && (state_r == S_RUN) && !(|rise);

    ////////////////////////////////////////////////////////////////////
    // Readback
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 16'h0;
        end else begin
            case (cmd)
                `CMD_OUT_UC_THR:    rd_data <= uc_thr_r;
                `CMD_OT_FAULT_THR:  rd_data <= otf_thr_r;
                `CMD_OT_WARN_THR:   rd_data <= otw_thr_r;
                `CMD_UT_WARN_THR:   rd_data <= utw_thr_r;
                `CMD_UT_FAULT_THR:  rd_data <= utf_thr_r;
                `CMD_VIN_OV_THR:    rd_data <= ovf_thr_r;
                `CMD_VIN_OV_WARN:   rd_data <= ovw_thr_r;
                `CMD_OT_ACTION:     rd_data <= {8'h0, `ACT_RSVD_VAL, ot_act_r};
                `CMD_UT_ACTION:     rd_data <= {8'h0, `ACT_RSVD_VAL, ut_act_r};
                `CMD_VIN_OV_ACTION: rd_data <= {8'h0, `ACT_RSVD_VAL, ov_act_r};
                `CMD_STATUS_BYTE:   rd_data <= {8'h0, status_word[7:0]};
                `CMD_STATUS_WORD:   rd_data <= status_word;
                default:            rd_data <= 16'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: tb/fault_limit_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_limit_props #(
    parameter STEP_CYC = 10
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        wr_en,
    input wire logic [7:0]  cmd,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    input wire logic        clear_faults,
    input wire logic [15:0] temp_meas,
    input wire logic [15:0] vin_meas,
    input wire logic        run_cmd,
    input wire logic [15:0] output_undercurrent_threshold,
    input wire logic        output_enable,
    input wire logic        alert_n
);
    logic [5:0] ot_a_r;
    logic [5:0] ut_a_r;
    logic [5:0] ov_a_r;
    int         off_cnt_r;
    wire        tu_hold = ot_a_r[5:3] != 3'h7 && ut_a_r[5:3] != 3'h7;
    wire        no_rty = tu_hold && ov_a_r[5:3] != 3'h7;
    wire        ov_rty = tu_hold && ov_a_r[5:3] == 3'h7;
    ////////////////////////////////////////////////////////////////
    // Mirror of action bytes, off-time counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ot_a_r <= 6'h00;
            ut_a_r <= 6'h00;
            ov_a_r <= 6'h00;
            off_cnt_r <= 0;
        end else begin
            if (wr_en && cmd == 8'h50) ot_a_r <= wr_data[5:0];
            if (wr_en && cmd == 8'h54) ut_a_r <= wr_data[5:0];
            if (wr_en && cmd == 8'h56) ov_a_r <= wr_data[5:0];
            off_cnt_r <= (output_enable || !run_cmd) ? 0 : off_cnt_r + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_ot_write;
        wr_en && cmd == 8'h4F ##1 !wr_en && cmd == 8'h4F;
    endsequence
    sequence s_status_read;
        (cmd == 8'h79) [*2];
    endsequence
    a_uc_thr_write: assert property (
        wr_en && cmd == 8'h4B |=> output_undercurrent_threshold == $past(wr_data))
        else $error("undercurrent threshold not written");
    a_ot_readback: assert property (
        s_ot_write |=> rd_data == $past(wr_data, 2))
        else $error("fault threshold readback wrong");
    a_action_reserved: assert property (
        (cmd == 8'h50 || cmd == 8'h54 || cmd == 8'h56) [*2] |=> rd_data[15:6] == 10'h002)
        else $error("action reserved bits wrong");
    a_status_bits: assert property (
        s_status_read |=> (rd_data & 16'hDFFA) == 16'h0000)
        else $error("status bit outside known set");
    a_alert_status: assert property (
        s_status_read ##1 (rd_data != 16'h0000 && !$past(clear_faults)) |-> !alert_n)
        else $error("status set without alert");
    a_alert_holds: assert property (
        !alert_n && !clear_faults |=> !alert_n)
        else $error("alert dropped without clear");
    a_enable_run: assert property (
        output_enable |-> run_cmd)
        else $error("output on while commanded off");
    a_noretry_hold: assert property (
        no_rty && run_cmd && $past(run_cmd) && !output_enable && !clear_faults
        |=> !output_enable)
        else $error("output restarted without clear");
    a_retry_bound: assert property (
        ov_rty && run_cmd |-> off_cnt_r <= (ov_a_r[2:0] + 1) * STEP_CYC + 2)
        else $error("retry delay too long");
endmodule
bind fault_limit_response_bank fault_limit_props #(.STEP_CYC(STEP_CYC)) u_props (
    .sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .cmd(cmd), .wr_data(wr_data),
    .rd_data(rd_data), .clear_faults(clear_faults), .temp_meas(temp_meas),
    .vin_meas(vin_meas), .run_cmd(run_cmd), .output_enable(output_enable),
    .output_undercurrent_threshold(output_undercurrent_threshold), .alert_n(alert_n));
`default_nettype wire

/* File: tb/mgmt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
    input  wire logic        sys_clk,
    output var  logic        wr_en,
    output var  logic [7:0]  cmd,
    output var  logic [15:0] wr_data,
    input  wire logic [15:0] rd_data
);
    initial begin
        wr_en = 1'b0;
        cmd = 8'h00;
        wr_data = 16'h0000;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        cmd <= c;
        wr_data <= v;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        wr_data <= ~v;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        @(posedge sys_clk);
        cmd <= c;
        repeat (2) @(posedge sys_clk);
        #1;
        v = rd_data;
    endtask
endmodule
`default_nettype wire

/* File: tb/fault_limit_response_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_limit_response_bank_test;
    localparam int STEP = 10;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clear_faults = 1'b0;
    logic        run_cmd = 1'b0;
    logic [15:0] temp_meas = 16'hE190;
    logic [15:0] vin_meas = 16'hD300;
    wire         wr_en;
    wire  [7:0]  cmd;
    wire  [15:0] wr_data;
    wire  [15:0] rd_data;
    wire  [15:0] uc_thr;
    wire         output_enable;
    wire         alert_n;
    int          mismatches = 0;
    int          total_checks = 0;
    int          n;
    logic        tw = 1'b0;
    logic        iw = 1'b0;
    logic [15:0] lfsr_r = 16'h0020;
    logic [15:0] d;
    logic [15:0] mdl [logic [7:0]];
    logic [7:0]  cmds [10] = '{8'h4B, 8'h4F, 8'h50, 8'h51, 8'h52,
                               8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
    logic [15:0] rv [10] = '{16'hDC3F, 16'hEBE8, 16'h0080, 16'hEB70, 16'hDC40,
                             16'hE530, 16'h0080, 16'hD3A0, 16'h0080, 16'hD34D};
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    mgmt_host_model host (.sys_clk(sys_clk), .wr_en(wr_en), .cmd(cmd),
                          .wr_data(wr_data), .rd_data(rd_data));
    fault_limit_response_bank #(.STEP_CYC(STEP)) DUT (
        .sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .cmd(cmd), .wr_data(wr_data),
        .rd_data(rd_data), .clear_faults(clear_faults), .temp_meas(temp_meas),
        .vin_meas(vin_meas), .run_cmd(run_cmd), .output_undercurrent_threshold(uc_thr),
        .output_enable(output_enable), .alert_n(alert_n));
    ////////////////////////////////////////////////////////////////
    function automatic longint l11(input logic [15:0] x);
        return longint'($signed(x[10:0])) <<< ($signed(x[15:11]) + 16);
    endfunction
    function automatic logic t_on(input logic [15:0] t);
        return l11(t) > l11(mdl[8'h51]) || l11(t) < l11(mdl[8'h52]);
    endfunction
    function automatic logic [15:0] lfsr();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return lfsr_r;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] c);
        host.rd(c, d);
        chk(d, mdl.exists(c) ? mdl[c] : 16'h0000);
    endtask
    task automatic wrm(input logic [7:0] c, input logic [15:0] v);
        host.wr(c, v);
        mdl[c] = (c inside {8'h50, 8'h54, 8'h56}) ? (16'h0080 | (v & 16'h003F)) : v;
    endtask
    task automatic env(input logic [15:0] t, input logic [15:0] v);
        @(posedge sys_clk);
        temp_meas <= t;
        vin_meas <= v;
        repeat (4) @(posedge sys_clk);
        #1;
        tw = tw | t_on(t);
        iw = iw | (l11(v) > l11(mdl[8'h57]));
    endtask
    task automatic clr();
        @(posedge sys_clk);
        clear_faults <= 1'b1;
        @(posedge sys_clk);
        clear_faults <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        tw = t_on(temp_meas);
        iw = l11(vin_meas) > l11(mdl[8'h57]);
    endtask
    task automatic st();
        mdl[8'h79] = {2'b00, iw, 10'h000, tw, 1'b0, iw};
        mdl[8'h78] = mdl[8'h79] & 16'h00FF;
        rc(8'h79);
        rc(8'h78);
        chk({15'h0000, alert_n}, {15'h0000, !(tw | iw)});
    endtask
    task automatic oe(input logic e);
        chk({15'h0000, output_enable}, {15'h0000, e});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        foreach (cmds[i]) mdl[cmds[i]] = rv[i];
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (cmds[i]) begin
            rc(cmds[i]);
            wrm(cmds[i], lfsr());
            rc(cmds[i]);
            wrm(cmds[i], rv[i]);
        end
        rc(8'h4C);
        chk(uc_thr, 16'hDC3F);
        clr();
        @(posedge sys_clk);
        run_cmd <= 1'b1;
        env(16'hEB98, 16'hD300);
        env(16'hE190, 16'hD300);
        st();
        clr();
        st();
        env(16'hF208, 16'hD300);
        oe(1'b0);
        env(16'hEB98, 16'hD300);
        clr();
        oe(1'b0);
        env(16'hEB20, 16'hD300);
        oe(1'b0);
        clr();
        oe(1'b1);
        env(16'hE4E0, 16'hD300);
        oe(1'b0);
        st();
        env(16'hE580, 16'hD300);
        clr();
        oe(1'b0);
        env(16'hE190, 16'hD300);
        clr();
        oe(1'b1);
        env(16'hE190, 16'hD360);
        st();
        env(16'hE190, 16'hD300);
        clr();
        d = lfsr() & 16'h0007;
        wrm(8'h56, 16'h0038 | d);
        @(posedge sys_clk);
        vin_meas <= 16'hD3C0;
        repeat (2) @(posedge sys_clk);
        #1;
        oe(1'b0);
        n = 0;
        while (!output_enable && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk({15'h0000, n >= (d + 1) * STEP - 3 && n <= (d + 1) * STEP + 2}, 16'h0001);
        oe(1'b1);
        @(posedge sys_clk);
        run_cmd <= 1'b0;
        @(posedge sys_clk);
        #1;
        oe(1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
